// file: rtl/sbp_port_regs.svh
`ifndef SBP_PORT_REGS_SVH
`define SBP_PORT_REGS_SVH

// Register indices on the plain register port
`define SBP_ADDR_W            4
`define SBP_OFF_PIN_A         4'h0
`define SBP_OFF_LAT_A         4'h1
`define SBP_OFF_DIR_A         4'h2
`define SBP_OFF_PIN_B         4'h3
`define SBP_OFF_LAT_B         4'h4
`define SBP_OFF_DIR_B         4'h5
`define SBP_OFF_MEM_CTL       4'h6
`define SBP_OFF_PSP_CTL       4'h7
`define SBP_OFF_CFG           4'h8

// Field positions
`define SBP_BIT_EXT_BUS_DIS   7
`define SBP_BIT_PSP_EN        4
`define SBP_BIT_PWM2_SEL      0
`define SBP_BIT_MCU_MODE      1

// Second-port strobe pins used by the parallel slave port
`define SBP_PIN_PSP_RD        0
`define SBP_PIN_PSP_WR        1
`define SBP_PIN_PSP_CS        2

// Reset values
`define SBP_RST_LAT           8'h00
`define SBP_RST_DIR           8'hFF
`define SBP_RST_EXT_BUS_DIS   1'b1
`define SBP_RST_PSP_EN        1'b0
`define SBP_RST_PWM2_SEL      1'b1
`define SBP_RST_MCU_MODE      1'b1

`endif

// file: rtl/sbp_port_pkg.sv
`default_nettype none

package sbp_port_pkg;

    // External memory interface outputs toward the pins
    typedef struct packed {
        logic        drive;
        logic [15:0] ad;
    } sbp_xbus_t;

    // Second serial port outputs toward the pins
    typedef struct packed {
        logic enable;
        logic sdo_drive;
        logic sdo;
        logic sda_low;
        logic sck;
    } sbp_ssp_t;

    // Enhanced PWM outputs toward the second port
    typedef struct packed {
        logic [7:0] active;
        logic [7:0] level;
        logic [7:0] shutdown;
    } sbp_pwm_t;

    // One 8-bit pin group
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] enable;
    } sbp_pins_t;

    typedef struct packed {
        logic [7:0] sync1_a;
        logic [7:0] sync2_a;
        logic [7:0] sync1_b;
        logic [7:0] sync2_b;
        logic [7:0] lat_a;
        logic [7:0] dir_a;
        logic [7:0] lat_b;
        logic [7:0] dir_b;
        logic       ext_bus_dis;
        logic       psp_en;
        logic       pwm2_sel;
        logic       mcu_mode;
        logic [7:0] rdata;
        sbp_pins_t  pins_a;
        sbp_pins_t  pins_b;
    } sbp_state_t;

endpackage : sbp_port_pkg

`default_nettype wire

// file: rtl/sbp_port_pair.sv
// Contract
// RQ1: Direction bit 1 puts the pin driver in high impedance.
// RQ2: Direction bit 0 drives the pin from its output latch.
// RQ3: Reading the latch register returns the latch, not the pin.
// RQ4: Second port has eight pins, each with its own direction bit.
// RQ5: Port and peripheral functions need the external bus disabled.
// RQ6: Enabled external bus drives second port as high address/data byte.
// RQ7: Parallel slave enable turns second-port pins 0..2 into strobe inputs.
// RQ8: Software must set direction bits of the strobe pins itself; code makes them inputs unless the bus or a PWM output at direction 0 drives them.
// RQ9: Second compare/PWM goes to second-port pin 7 when selected.
// RQ10: External bus outputs override PWM and latch on second port.
// RQ11: External bus overrides slave, serial and latch on pins 5, 6.
// RQ12: Parallel slave mode drives latch on reads, accepts written data.
// RQ13: Serial data and clock outputs override slave and latch data.
// RQ14: Serial clock pin is output at direction 0, input at 1.
// RQ15: First-port pin 7 is serial slave select when direction is 1.
// RQ16: PWM outputs override latch, tri-state during shutdown.
// RQ17: External bus functions exist only in the large package.
// RQ18: Each second-port pin selects input or output independently.
// RQ19: After reset all direction bits are 1, all pins inputs.
// RQ20: Enabled external bus drives first port as low address/data byte.
// RQ21: Port register write updates latch, read returns pin levels.
`include "sbp_port_regs.svh"
`default_nettype none

module sbp_port_pair
    import sbp_port_pkg::*;
#(
    parameter int PORT_W    = 8,
    parameter bit LARGE_PKG = 1'b1
)(
    // Clock, reset, enable
    input  wire logic                   clk_in,
    input  wire logic                   reset_in,
    input  wire logic                   clk_en_in,
    // Register port
    input  wire logic [`SBP_ADDR_W-1:0] reg_addr_in,
    input  wire logic [7:0]             reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic [7:0]                  reg_rdata_out,
    // First port pins
    input  wire logic [7:0]             port_a_pin_in,
    output logic [7:0]                  port_a_pin_out,
    output logic [7:0]                  port_a_pin_oe_out,
    // Second port pins
    input  wire logic [7:0]             port_b_pin_in,
    output logic [7:0]                  port_b_pin_out,
    output logic [7:0]                  port_b_pin_oe_out,
    // Peripherals taking over the pins
    input  wire sbp_xbus_t              xbus_in,
    input  wire sbp_ssp_t               ssp_in,
    input  wire sbp_pwm_t               pwm_in,
    // Pin levels back to the peripherals
    output logic                        xbus_on_out,
    output logic [15:0]                 xbus_data_out,
    output logic [7:0]                  psp_data_out,
    output logic                        psp_read_out,
    output logic                        psp_write_out,
    output logic                        ssp_sdi_out,
    output logic                        ssp_sck_out,
    output logic                        ssp_slave_sel_n_out
);

    if (PORT_W != 8) begin : g_bad_width
        $error("sbp_port_pair serves 8-bit ports only");
    end

    localparam sbp_state_t RESET_STATE = '{
        sync1_a     : 8'h00,
        sync2_a     : 8'h00,
        sync1_b     : 8'h00,
        sync2_b     : 8'h00,
        lat_a       : `SBP_RST_LAT,
        dir_a       : `SBP_RST_DIR,
        lat_b       : `SBP_RST_LAT,
        dir_b       : `SBP_RST_DIR,
        ext_bus_dis : `SBP_RST_EXT_BUS_DIS,
        psp_en      : `SBP_RST_PSP_EN,
        pwm2_sel    : `SBP_RST_PWM2_SEL,
        mcu_mode    : `SBP_RST_MCU_MODE,
        rdata       : 8'h00,
        pins_a      : '{value: 8'h00, enable: 8'h00},
        pins_b      : '{value: 8'h00, enable: 8'h00}
    };

    sbp_state_t st_ff;
    sbp_state_t nxt_st;

    logic       bus_on;
    logic       psp_rd_act;
    logic       psp_wr_act;
    logic [7:0] ssp_oe_a;
    logic [7:0] ssp_val_a;
    logic [7:0] pwm_ok_b;
    sbp_pins_t  sel_a;
    sbp_pins_t  sel_b;

    // Small package has no bus; bus owns both ports when enabled
    assign bus_on = LARGE_PKG && !st_ff.ext_bus_dis;  // [RQ5] [RQ17]

    // Strobes are active low on the pins, read from synced copies
    assign psp_rd_act = st_ff.psp_en
        && !st_ff.sync2_b[`SBP_PIN_PSP_RD]
        && !st_ff.sync2_b[`SBP_PIN_PSP_CS];  // [RQ7]
    assign psp_wr_act = st_ff.psp_en
        && !st_ff.sync2_b[`SBP_PIN_PSP_WR]
        && !st_ff.sync2_b[`SBP_PIN_PSP_CS];  // [RQ7]

    // Serial outputs: data pin 4, open-drain data pin 5, clock pin 6
    assign ssp_oe_a = {
        1'b0,
        ssp_in.enable && !st_ff.dir_a[6],  // [RQ14]
        ssp_in.enable && ssp_in.sda_low,
        ssp_in.enable && ssp_in.sdo_drive && !st_ff.dir_a[4],
        4'h0
    };  // [RQ13]
    assign ssp_val_a = {1'b0, ssp_in.sck, 1'b0, ssp_in.sdo, 4'h0};

    for (genvar i = 0; i < 8; i++) begin : g_pin
        // PWM channel on pin 7 only when routed there
        if (i == 7) begin : g_alt
            assign pwm_ok_b[i] = pwm_in.active[i] && !st_ff.dir_b[i]
                && st_ff.mcu_mode && !st_ff.pwm2_sel;  // [RQ9]
        end
        else begin : g_fix
            assign pwm_ok_b[i] = pwm_in.active[i] && !st_ff.dir_b[i];
        end

        always_comb
        begin
            if (bus_on)
            begin
                sel_a.enable[i] = xbus_in.drive;  // [RQ11] [RQ20]
                sel_a.value[i]  = xbus_in.ad[i];
            end
            else if (ssp_oe_a[i])
            begin
                sel_a.enable[i] = 1'b1;  // [RQ13]
                sel_a.value[i]  = ssp_val_a[i];
            end
            else if (st_ff.psp_en)
            begin
                sel_a.enable[i] = psp_rd_act;  // [RQ12]
                sel_a.value[i]  = st_ff.lat_a[i];
            end
            else
            begin
                sel_a.enable[i] = !st_ff.dir_a[i];  // [RQ1] [RQ2]
                sel_a.value[i]  = st_ff.lat_a[i];
            end
        end

        always_comb
        begin
            if (bus_on)
            begin
                sel_b.enable[i] = xbus_in.drive;  // [RQ6] [RQ10]
                sel_b.value[i]  = xbus_in.ad[8+i];
            end
            else if (pwm_ok_b[i])
            begin
                sel_b.enable[i] = !pwm_in.shutdown[i];  // [RQ16]
                sel_b.value[i]  = pwm_in.level[i];
            end
            else if (st_ff.psp_en && i <= `SBP_PIN_PSP_CS)
            begin
                // Strobe pins stay inputs whatever the latch holds
                sel_b.enable[i] = 1'b0;  // [RQ7] [RQ8]
                sel_b.value[i]  = st_ff.lat_b[i];
            end
            else
            begin
                sel_b.enable[i] = !st_ff.dir_b[i];  // [RQ4] [RQ18]
                sel_b.value[i]  = st_ff.lat_b[i];
            end
        end
    end

    always_comb
    begin
        nxt_st = st_ff;
        if (clk_en_in)
        begin
            nxt_st.sync1_a = port_a_pin_in;
            nxt_st.sync2_a = st_ff.sync1_a;
            nxt_st.sync1_b = port_b_pin_in;
            nxt_st.sync2_b = st_ff.sync1_b;
            // Pin drive is registered so outputs never glitch
            nxt_st.pins_a  = sel_a;
            nxt_st.pins_b  = sel_b;
            nxt_st.rdata   = 8'h00;

            if (reg_wr_in)
            begin
                if (reg_addr_in == `SBP_OFF_PIN_A)
                    nxt_st.lat_a = reg_wdata_in;  // [RQ21]
                else if (reg_addr_in == `SBP_OFF_LAT_A)
                    nxt_st.lat_a = reg_wdata_in;  // [RQ3]
                else if (reg_addr_in == `SBP_OFF_DIR_A)
                    nxt_st.dir_a = reg_wdata_in;
                else if (reg_addr_in == `SBP_OFF_PIN_B)
                    nxt_st.lat_b = reg_wdata_in;  // [RQ21]
                else if (reg_addr_in == `SBP_OFF_LAT_B)
                    nxt_st.lat_b = reg_wdata_in;  // [RQ3]
                else if (reg_addr_in == `SBP_OFF_DIR_B)
                    nxt_st.dir_b = reg_wdata_in;  // [RQ18]
                else if (reg_addr_in == `SBP_OFF_MEM_CTL)
                    nxt_st.ext_bus_dis =
                        reg_wdata_in[`SBP_BIT_EXT_BUS_DIS];  // [RQ5]
                else if (reg_addr_in == `SBP_OFF_PSP_CTL)
                    nxt_st.psp_en = reg_wdata_in[`SBP_BIT_PSP_EN];
                else if (reg_addr_in == `SBP_OFF_CFG)
                begin
                    nxt_st.pwm2_sel = reg_wdata_in[`SBP_BIT_PWM2_SEL];
                    nxt_st.mcu_mode = reg_wdata_in[`SBP_BIT_MCU_MODE];
                end
            end

            if (reg_rd_in)
            begin
                if (reg_addr_in == `SBP_OFF_PIN_A)
                    nxt_st.rdata = st_ff.sync2_a;  // [RQ21]
                else if (reg_addr_in == `SBP_OFF_LAT_A)
                    nxt_st.rdata = st_ff.lat_a;  // [RQ3]
                else if (reg_addr_in == `SBP_OFF_DIR_A)
                    nxt_st.rdata = st_ff.dir_a;
                else if (reg_addr_in == `SBP_OFF_PIN_B)
                    nxt_st.rdata = st_ff.sync2_b;  // [RQ21]
                else if (reg_addr_in == `SBP_OFF_LAT_B)
                    nxt_st.rdata = st_ff.lat_b;  // [RQ3]
                else if (reg_addr_in == `SBP_OFF_DIR_B)
                    nxt_st.rdata = st_ff.dir_b;
                else if (reg_addr_in == `SBP_OFF_MEM_CTL)
                    nxt_st.rdata = {st_ff.ext_bus_dis, 7'h00};
                else if (reg_addr_in == `SBP_OFF_PSP_CTL)
                    nxt_st.rdata = {3'h0, st_ff.psp_en, 4'h0};
                else if (reg_addr_in == `SBP_OFF_CFG)
                    nxt_st.rdata = {6'h00, st_ff.mcu_mode, st_ff.pwm2_sel};
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            st_ff <= RESET_STATE;  // [RQ19]
        else
            st_ff <= nxt_st;
    end

    assign reg_rdata_out       = st_ff.rdata;
    assign port_a_pin_out      = st_ff.pins_a.value;
    assign port_a_pin_oe_out   = st_ff.pins_a.enable;
    assign port_b_pin_out      = st_ff.pins_b.value;
    assign port_b_pin_oe_out   = st_ff.pins_b.enable;
    assign xbus_on_out         = bus_on;
    assign xbus_data_out       = {st_ff.sync2_b, st_ff.sync2_a};
    assign psp_data_out        = st_ff.sync2_a;  // [RQ12]
    assign psp_read_out        = psp_rd_act && !bus_on;
    assign psp_write_out       = psp_wr_act && !bus_on;
    assign ssp_sdi_out         = st_ff.sync2_a[5];
    assign ssp_sck_out         = st_ff.sync2_a[6];
    // Slave select reads inactive while pin 7 is an output
    assign ssp_slave_sel_n_out =
        st_ff.dir_a[7] ? st_ff.sync2_a[7] : 1'b1;  // [RQ15]

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    a_reset_all_inputs: assert property ( // [RQ19]
        $past(reset_in) |-> st_ff.dir_a == 8'hFF && st_ff.dir_b == 8'hFF
            && port_a_pin_oe_out == 8'h00 && port_b_pin_oe_out == 8'h00)
        else $error("pins not inputs after reset");

    a_input_hiz: assert property ( // [RQ1]
        clk_en_in && !bus_on && !st_ff.psp_en && st_ff.dir_a[0]
            |=> !port_a_pin_oe_out[0])
        else $error("input pin still driven");

    a_output_latch: assert property ( // [RQ2]
        clk_en_in && !bus_on && !st_ff.psp_en && !st_ff.dir_a[1]
            |=> port_a_pin_oe_out[1]
                && port_a_pin_out[1] == $past(st_ff.lat_a[1]))
        else $error("output pin not driving latch");

    a_latch_readback: assert property ( // [RQ3]
        clk_en_in && reg_rd_in && reg_addr_in == `SBP_OFF_LAT_A
            |=> reg_rdata_out == $past(st_ff.lat_a))
        else $error("latch read returned wrong value");

    a_pin_readback: assert property ( // [RQ21]
        clk_en_in && reg_rd_in && reg_addr_in == `SBP_OFF_PIN_B
            |=> reg_rdata_out == $past(port_b_pin_in, 3))
        else $error("pin read not pin level");

    a_bus_high_byte: assert property ( // [RQ6]
        clk_en_in && bus_on
            |=> port_b_pin_oe_out == {8{$past(xbus_in.drive)}}
                && port_b_pin_out == $past(xbus_in.ad[15:8]))
        else $error("bus byte missing on second port");

    a_strobe_inputs: assert property ( // [RQ7]
        clk_en_in && !bus_on && st_ff.psp_en && pwm_in.active[2:0] == 3'h0
            |=> port_b_pin_oe_out[2:0] == 3'h0)
        else $error("strobe pin driven in slave mode");

    a_sck_master: assert property ( // [RQ14]
        clk_en_in && !bus_on && ssp_in.enable && !st_ff.dir_a[6]
            |=> port_a_pin_oe_out[6]
                && port_a_pin_out[6] == $past(ssp_in.sck))
        else $error("serial clock not driven as master");

    a_pwm_shutdown: assert property ( // [RQ16]
        clk_en_in && !bus_on && pwm_in.active[3] && !st_ff.dir_b[3]
            && pwm_in.shutdown[3] |=> !port_b_pin_oe_out[3])
        else $error("pwm pin driven during shutdown");

    a_pwm_alt_pin: assert property ( // [RQ9]
        clk_en_in && !bus_on && st_ff.pwm2_sel && !st_ff.psp_en
            |=> port_b_pin_oe_out[7] == !$past(st_ff.dir_b[7])
                && port_b_pin_out[7] == $past(st_ff.lat_b[7]))
        else $error("pwm reached pin 7 while not routed");

    a_bus_low_byte: assert property ( // [RQ20]
        clk_en_in && bus_on
            |=> port_a_pin_oe_out == {8{$past(xbus_in.drive)}}
                && port_a_pin_out == $past(xbus_in.ad[7:0]))
        else $error("bus byte missing on first port");

    a_bus_over_pwm: assert property ( // [RQ10]
        clk_en_in && bus_on && pwm_in.active[3] && !st_ff.dir_b[3]
            |=> port_b_pin_out[3] == $past(xbus_in.ad[11]))
        else $error("pwm won over the external bus");

    a_bus_over_serial: assert property ( // [RQ11]
        clk_en_in && bus_on && ssp_in.enable
            |=> port_a_pin_out[6:5] == $past(xbus_in.ad[6:5])
                && port_a_pin_oe_out[6:5] == {2{$past(xbus_in.drive)}})
        else $error("serial port won over the external bus");

    a_slave_read_drive: assert property ( // [RQ12]
        clk_en_in && !bus_on && st_ff.psp_en && !ssp_in.enable
            |=> port_a_pin_oe_out == {8{$past(psp_rd_act)}}
                && port_a_pin_out == $past(st_ff.lat_a))
        else $error("slave read data not driven from latch");

    a_serial_data_out: assert property ( // [RQ13]
        clk_en_in && !bus_on && ssp_in.enable && ssp_in.sdo_drive
            && !st_ff.dir_a[4]
            |=> port_a_pin_oe_out[4]
                && port_a_pin_out[4] == $past(ssp_in.sdo))
        else $error("serial data output not driven");

    a_sck_input: assert property ( // [RQ14]
        clk_en_in && !bus_on && !st_ff.psp_en && st_ff.dir_a[6]
            |=> !port_a_pin_oe_out[6])
        else $error("serial clock driven while an input");

    // Only meaningful once both sync stages have run free of reset
    a_select_follows: assert property ( // [RQ15]
        st_ff.dir_a[7] && $past(clk_en_in) && $past(clk_en_in, 2)
            && !$past(reset_in) && !$past(reset_in, 2)
            |-> ssp_slave_sel_n_out == $past(port_a_pin_in[7], 2))
        else $error("slave select does not follow its pin");

    a_bus_gate: assert property ( // [RQ5] [RQ17]
        st_ff.ext_bus_dis || !LARGE_PKG |-> !xbus_on_out)
        else $error("external bus on while disabled");

    a_dir_b_each: assert property ( // [RQ18]
        clk_en_in && !bus_on && !st_ff.psp_en && pwm_in.active == 8'h00
            |=> port_b_pin_oe_out == ~$past(st_ff.dir_b))
        else $error("second port pin direction not per bit");

endmodule : sbp_port_pair

`default_nettype wire

// file: bench/sbp_port_pair_tb.sv
`include "sbp_port_regs.svh"
`default_nettype none

module sbp_port_pair_tb
    import sbp_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk_in;
    logic                   reset_in;
    logic                   clk_en;
    logic [`SBP_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic [7:0]             rdata;
    logic                   wr;
    logic                   rd;
    logic [7:0]             pa_in;
    logic [7:0]             pa_out;
    logic [7:0]             pa_oe;
    logic [7:0]             pb_in;
    logic [7:0]             pb_out;
    logic [7:0]             pb_oe;
    sbp_xbus_t              xbus;
    sbp_ssp_t               ssp;
    sbp_pwm_t               pwm;
    logic                   xbus_on;
    logic [15:0]            xbus_data;
    logic [7:0]             psp_data;
    logic                   psp_rd;
    logic                   psp_wr;
    logic                   sdi;
    logic                   sck;
    logic                   ss_n;
    int                     errors;
    int                     tests_run;
    logic                   small_on;
    logic [7:0]             small_a_oe;

    sbp_port_pair sbp_port_pair_i (
        .clk_in              (clk_in),
        .reset_in            (reset_in),
        .clk_en_in           (clk_en),
        .reg_addr_in         (addr),
        .reg_wdata_in        (wdata),
        .reg_wr_in           (wr),
        .reg_rd_in           (rd),
        .reg_rdata_out       (rdata),
        .port_a_pin_in       (pa_in),
        .port_a_pin_out      (pa_out),
        .port_a_pin_oe_out   (pa_oe),
        .port_b_pin_in       (pb_in),
        .port_b_pin_out      (pb_out),
        .port_b_pin_oe_out   (pb_oe),
        .xbus_in             (xbus),
        .ssp_in              (ssp),
        .pwm_in              (pwm),
        .xbus_on_out         (xbus_on),
        .xbus_data_out       (xbus_data),
        .psp_data_out        (psp_data),
        .psp_read_out        (psp_rd),
        .psp_write_out       (psp_wr),
        .ssp_sdi_out         (sdi),
        .ssp_sck_out         (sck),
        .ssp_slave_sel_n_out (ss_n)
    );

    // Small package variant sees the same stimulus but has no bus
    sbp_port_pair #(
        .LARGE_PKG (1'b0)
    ) sbp_port_pair_small_i (
        .clk_in              (clk_in),
        .reset_in            (reset_in),
        .clk_en_in           (clk_en),
        .reg_addr_in         (addr),
        .reg_wdata_in        (wdata),
        .reg_wr_in           (wr),
        .reg_rd_in           (rd),
        .reg_rdata_out       (),
        .port_a_pin_in       (pa_in),
        .port_a_pin_out      (),
        .port_a_pin_oe_out   (small_a_oe),
        .port_b_pin_in       (pb_in),
        .port_b_pin_out      (),
        .port_b_pin_oe_out   (),
        .xbus_in             (xbus),
        .ssp_in              (ssp),
        .pwm_in              (pwm),
        .xbus_on_out         (small_on),
        .xbus_data_out       (),
        .psp_data_out        (),
        .psp_read_out        (),
        .psp_write_out       (),
        .ssp_sdi_out         (),
        .ssp_sck_out         (),
        .ssp_slave_sel_n_out ()
    );

    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    task automatic conclude();
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m,
                          input logic [7:0] exp);
        @(posedge clk_in);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd   <= 1'b0;
        #1;
        chk(rdata & m, exp);
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : settle

    // Pins pass two sync flops, so allow a few edges
    task automatic pins(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_in);
        pa_in <= a;
        pb_in <= b;
    endtask : pins

    initial
    begin
        #100_000;
        errors++;
        conclude();
    end

    initial
    begin
        errors    = 0;
        tests_run = 0;
        reset_in  = 1'b1;
        clk_en    = 1'b1;
        addr      = '0;
        wdata     = 8'h00;
        wr        = 1'b0;
        rd        = 1'b0;
        pa_in     = 8'h00;
        pb_in     = 8'h00;
        xbus      = '0;
        ssp       = '0;
        pwm       = '0;
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        settle(1);
        chk({pb_oe, pa_oe}, 16'h0000);
        rd_chk(`SBP_OFF_DIR_A, 8'hFF, 8'hFF);
        rd_chk(`SBP_OFF_DIR_B, 8'hFF, 8'hFF);
        rd_chk(`SBP_OFF_LAT_A, 8'hFF, 8'h00);
        rd_chk(`SBP_OFF_LAT_B, 8'hFF, 8'h00);
        rd_chk(`SBP_OFF_MEM_CTL, 8'h80, 8'h80);
        rd_chk(`SBP_OFF_PSP_CTL, 8'h10, 8'h00);
        rd_chk(`SBP_OFF_CFG, 8'h03, 8'h03);
        wr_reg(`SBP_OFF_LAT_A, 8'hFF);
        wr_reg(`SBP_OFF_DIR_A, 8'hA5);
        settle(2);
        chk(pa_oe, 8'h5A);
        chk(pa_out & pa_oe, 8'h5A);
        wr_reg(`SBP_OFF_LAT_B, 8'hFF);
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(`SBP_OFF_DIR_B, ~(8'h01 << i));
            settle(2);
            chk(pb_oe, 8'h01 << i);
            chk(pb_out & pb_oe, 8'h01 << i);
        end
        pins(8'hC3, 8'h3C);
        settle(4);
        rd_chk(`SBP_OFF_PIN_A, 8'hFF, 8'hC3);
        rd_chk(`SBP_OFF_PIN_B, 8'hFF, 8'h3C);
        rd_chk(`SBP_OFF_LAT_A, 8'hFF, 8'hFF);
        wr_reg(`SBP_OFF_PIN_A, 8'h5A);
        rd_chk(`SBP_OFF_LAT_A, 8'hFF, 8'h5A);
        rd_chk(`SBP_OFF_PIN_A, 8'hFF, 8'hC3);
        wr_reg(`SBP_OFF_PIN_B, 8'hA5);
        rd_chk(`SBP_OFF_LAT_B, 8'hFF, 8'hA5);
        // A write with the enable low is lost
        @(posedge clk_in);
        clk_en <= 1'b0;
        wr_reg(`SBP_OFF_LAT_A, 8'h11);
        @(posedge clk_in);
        clk_en <= 1'b1;
        rd_chk(`SBP_OFF_LAT_A, 8'hFF, 8'h5A);
        wr_reg(4'h9, 8'hFF);
        rd_chk(4'h9, 8'hFF, 8'h00);
        rd_chk(4'hF, 8'hFF, 8'h00);
        rd_chk(`SBP_OFF_LAT_A, 8'hFF, 8'h5A);
        // Serial functions on the first port
        wr_reg(`SBP_OFF_LAT_A, 8'h00);
        @(posedge clk_in);
        ssp <= '{enable: 1'b1, sdo_drive: 1'b1, sdo: 1'b1,
                 sda_low: 1'b0, sck: 1'b1};
        settle(3);
        chk({pa_oe[6], pa_out[6], pa_oe[4], pa_out[4]}, 4'hF);
        pins(8'h43, 8'h3C);
        settle(4);
        chk(ss_n, 1'b0);
        wr_reg(`SBP_OFF_DIR_A, 8'h25);
        settle(3);
        chk(ss_n, 1'b1);
        wr_reg(`SBP_OFF_DIR_A, 8'hE5);
        settle(3);
        chk(pa_oe[6], 1'b0);
        chk({sck, sdi}, 2'b10);
        // PWM on the second port
        wr_reg(`SBP_OFF_LAT_B, 8'h00);
        wr_reg(`SBP_OFF_DIR_B, 8'h00);
        @(posedge clk_in);
        pwm <= '{active: 8'h88, level: 8'h88, shutdown: 8'h00};
        settle(3);
        chk(pb_oe & 8'h88, 8'h88);
        chk(pb_out & 8'h88, 8'h08);
        wr_reg(`SBP_OFF_CFG, 8'h02);
        settle(3);
        chk(pb_out & 8'h88, 8'h88);
        @(posedge clk_in);
        pwm.shutdown <= 8'h08;
        settle(3);
        chk(pb_oe & 8'h08, 8'h00);
        wr_reg(`SBP_OFF_CFG, 8'h00);
        settle(3);
        chk(pb_out & 8'h80, 8'h00);
        // External bus wins over every other function
        @(posedge clk_in);
        xbus <= '{drive: 1'b1, ad: 16'hA55A};
        wr_reg(`SBP_OFF_MEM_CTL, 8'h00);
        settle(3);
        chk(xbus_on, 1'b1);
        chk({small_on, small_a_oe}, 9'h01A);
        chk({pb_oe, pa_oe}, 16'hFFFF);
        chk({pb_out, pa_out}, 16'hA55A);
        chk(xbus_data, 16'h3C43);
        @(posedge clk_in);
        xbus.drive <= 1'b0;
        settle(3);
        chk({pb_oe, pa_oe}, 16'h0000);
        wr_reg(`SBP_OFF_MEM_CTL, 8'h80);
        settle(3);
        chk(xbus_on, 1'b0);
        // Parallel slave port
        @(posedge clk_in);
        pwm <= '0;
        ssp <= '0;
        wr_reg(`SBP_OFF_DIR_A, 8'hFF);
        wr_reg(`SBP_OFF_LAT_A, 8'h96);
        wr_reg(`SBP_OFF_DIR_B, 8'h07);
        wr_reg(`SBP_OFF_PSP_CTL, 8'h10);
        pins(8'hFF, 8'hFA);
        settle(5);
        chk(pb_oe, 8'hF8);
        chk({psp_rd, psp_wr}, 2'b10);
        chk({pa_oe, pa_out}, 16'hFF96);
        pins(8'h3C, 8'hF9);
        settle(5);
        chk({psp_rd, psp_wr}, 2'b01);
        chk(psp_data, 8'h3C);
        chk(pa_oe, 8'h00);
        conclude();
    end

endmodule : sbp_port_pair_tb

`default_nettype wire
